//--- rtl/psc_defs.svh
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH
`define PSC_NCH        28
`define PSC_NPIN       12
`define PSC_NSYNC      49
`define PSC_AW         8
`define PSC_A_CTRL     8'h00
`define PSC_A_DSEL     8'h04
`define PSC_A_ROUTE    8'h08
`define PSC_A_STAT     8'h0C
`define PSC_A_OECMD    8'h10
`define PSC_A_PEN      8'h14
`define PSC_A_LSCFG    8'h18
`define PSC_A_LSCFGE   8'h1C
`define PSC_A_BRCFG    8'h20
`define PSC_A_BRCFGB   8'h24
`define PSC_A_IGCFG    8'h28
`define PSC_A_CMD      8'h2C
`define PSC_INJ_HI     3
`define PSC_INJ_LO     0
`define PSC_IGN_HI     27
`define PSC_IGN_LO     24
`define PSC_IGNP_HI    7
`define PSC_IGNP_LO    4
`define PSC_RT_LO      4
`define PSC_RT_HI      23
`define PSC_RT_PIN0    8
`define PSC_NRT        4
`define PSC_RT_W       5
`define PSC_RTR_W      20
`define PSC_CH_A       16
`define PSC_CH_B       20
`define PSC_LS_W       24
`define PSC_LSE_W      25
`define PSC_DLY_A_BIT  24
`define PSC_DLY_B_BIT  0
`define PSC_BR_W       12
`define PSC_BR_FULL_A  8
`define PSC_IG_W       10
`define PSC_CMD_BIT    0
`define PSC_OE_BIT     0
`define PSC_ST_OE      0
`define PSC_ST_TOUT    1
`define PSC_ST_BATOV   2
`define PSC_ST_HOLD_A  3
`define PSC_ST_HOLD_B  4
`define PSC_ST_CONF    5
`define PSC_CLK_KHZ    100000
`define PSC_DLY_OFF_MS 400
`define PSC_DLY_CNT_W  27
`define PSC_HTRANS_VLD 1
`endif

//--- rtl/psc_pkg.sv
`include "psc_defs.svh"
package psc_pkg;
	typedef logic [`PSC_NCH-1:0] psc_chan_t;
	typedef enum logic {
		PSC_DLY_IDLE = 1'b0,
		PSC_DLY_HOLD = 1'b1
	} psc_dly_state_t;
endpackage : psc_pkg

//--- rtl/psc_dly_if.sv
`timescale 1ns/1ps
interface psc_dly_if;
	logic mode;
	logic keep;
	logic on_now;
	logic trigger;
	logic restart;
	logic ready;
	logic hold;
	modport ctl (output mode, keep, on_now, trigger, restart, ready,
		input hold);
	modport tmr (input mode, keep, on_now, trigger, restart, ready,
		output hold);
endinterface : psc_dly_if

//--- rtl/psc_sync.sv
`timescale 1ns/1ps
module psc_sync import psc_pkg::*; (
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	input  wire logic [`PSC_NSYNC-1:0] d,
	output logic      [`PSC_NSYNC-1:0] q
);
	logic [`PSC_NSYNC-1:0] meta_ff;
	logic [`PSC_NSYNC-1:0] q_ff;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule : psc_sync

//--- rtl/psc_dly_off.sv
`timescale 1ns/1ps
module psc_dly_off import psc_pkg::*; #(
	parameter int unsigned DLY_CYCLES = `PSC_DLY_OFF_MS * `PSC_CLK_KHZ
) (
	input  wire logic  ref_clk,
	input  wire logic  resetn,
	psc_dly_if.tmr     dif
);
	localparam logic [`PSC_DLY_CNT_W-1:0] LAST =
		`PSC_DLY_CNT_W'(DLY_CYCLES - 1);

	psc_dly_state_t              state_ff;
	psc_dly_state_t              nxt_state;
	logic [`PSC_DLY_CNT_W-1:0]   cnt_ff;
	logic                        ovf;
	logic                        stop;

	// A restart in the overflow cycle wins, so the hold is extended.
	assign ovf  = (cnt_ff == LAST) && !dif.restart;
	assign stop = ovf || !dif.keep || !dif.mode
		|| (dif.ready && !dif.trigger);

	always_comb begin
		case (state_ff)
			PSC_DLY_IDLE: nxt_state = (dif.mode && dif.on_now && dif.trigger)
				? PSC_DLY_HOLD : PSC_DLY_IDLE;
			PSC_DLY_HOLD: nxt_state = stop ? PSC_DLY_IDLE : PSC_DLY_HOLD;
			default: nxt_state = PSC_DLY_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn)
			state_ff <= PSC_DLY_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn)
			cnt_ff <= '0;
		else if (state_ff != PSC_DLY_HOLD || dif.restart)
			cnt_ff <= '0;
		else
			cnt_ff <= cnt_ff + `PSC_DLY_CNT_W'(1);
	end

	assign dif.hold = (state_ff == PSC_DLY_HOLD);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_start;
		state_ff == PSC_DLY_IDLE && dif.mode && dif.on_now && dif.trigger;
	endsequence

	a_hold_start: assert property (s_start |=> dif.hold)
		else $error("delayed hold did not start");
	a_timer_restart: assert property (dif.restart |=> cnt_ff == '0)
		else $error("restart did not clear the timer");
	a_hold_bound: assert property (dif.hold && cnt_ff == LAST
		&& !dif.restart |=> !dif.hold)
		else $error("hold outlived its on time");
	a_mode_end: assert property (dif.hold && !dif.mode |=> !dif.hold)
		else $error("hold kept after mode cleared");
endmodule : psc_dly_off

//--- rtl/psc_top.sv
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module psc_top import psc_pkg::*; #(
	parameter int unsigned DLY_CYCLES = `PSC_DLY_OFF_MS * `PSC_CLK_KHZ
) (
	input  wire logic                 ref_clk,
	input  wire logic                 resetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic [`PSC_NPIN-1:0] direct_drive_pin,
	input  wire logic                 injector_enable_pin,
	input  wire logic                 ignition_enable_pin,
	input  wire logic                 downlink_timeout,
	input  wire logic                 bat_overvoltage,
	input  wire logic                 main_supply_uv,
	input  wire logic                 main_supply_ov,
	input  wire logic                 monitor_n,
	input  wire logic                 reset_pin_n,
	input  wire logic                 ready_state,
	input  wire logic [`PSC_NCH-1:0]  protect_active,
	output logic [`PSC_NCH-1:0]       power_out,
	output logic [`PSC_LS_W-1:0]      lowside_oc_limit,
	output logic [`PSC_LS_W-1:0]      lowside_diag_pull,
	output logic [`PSC_BR_W-1:0]      bridge_mode,
	output logic [`PSC_IG_W-1:0]      ignition_openload_cfg,
	output logic                      relay_output_delayed,
	output logic                      bridge_output_delayed
);
	localparam psc_chan_t PAIR = (psc_chan_t'(1) << `PSC_CH_A)
		| (psc_chan_t'(1) << `PSC_CH_B);

	function automatic logic psc_wr_hit(input logic en,
		input logic [`PSC_AW-1:0] a, input logic [`PSC_AW-1:0] off);
		return en && (a == off);
	endfunction : psc_wr_hit

	function automatic logic psc_route_hit(
		input logic [`PSC_RT_W-1:0] r, input int ch);
		return (int'(r) == ch) && (ch >= `PSC_RT_LO)
			&& (ch <= `PSC_RT_HI);
	endfunction : psc_route_hit

	logic [`PSC_NSYNC-1:0] sync_q;
	psc_chan_t             prot_s;
	logic [`PSC_NPIN-1:0]  pin_s;
	logic                  inj_s;
	logic                  ign_s;
	logic                  tout_s;
	logic                  bat_s;
	logic                  uv_s;
	logic                  ov_s;
	logic                  mon_s;
	logic                  rstp_s;
	logic                  rdy_s;

	psc_sync u_sync (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.d       ({protect_active, direct_drive_pin, injector_enable_pin,
			ignition_enable_pin, downlink_timeout, bat_overvoltage,
			main_supply_uv, main_supply_ov, monitor_n, reset_pin_n,
			ready_state}),
		.q       (sync_q)
	);

	assign {prot_s, pin_s, inj_s, ign_s, tout_s, bat_s, uv_s, ov_s,
		mon_s, rstp_s, rdy_s} = sync_q;

	logic                  wr_ff;
	logic                  rd_ff;
	logic [`PSC_AW-1:0]    addr_ff;
	logic [31:0]           hrdata_ff;
	logic [31:0]           rd_val;
	logic                  acc;

	assign acc = hsel && htrans[`PSC_HTRANS_VLD] && hready;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wr_ff   <= 1'b0;
			rd_ff   <= 1'b0;
			addr_ff <= '0;
		end else begin
			wr_ff <= acc && hwrite;
			rd_ff <= acc && !hwrite;
			if (acc)
				addr_ff <= haddr[`PSC_AW-1:0];
		end
	end

	// Reads take one wait state so a write just before is always seen.
	assign hreadyout = !rd_ff;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;

	always_ff @(posedge ref_clk) begin
		if (!resetn)
			hrdata_ff <= '0;
		else if (rd_ff)
			hrdata_ff <= rd_val;
	end

	psc_chan_t                ctl_ff;
	psc_chan_t                dsel_ff;
	logic [`PSC_RTR_W-1:0]    route_ff;
	logic                     oe_ff;
	psc_chan_t                per_en_ff;
	logic [`PSC_LS_W-1:0]     lscfg_ff;
	logic [`PSC_LSE_W-1:0]    lscfge_ff;
	logic [`PSC_BR_W-1:0]     brcfg_ff;
	logic                     brcfgb_ff;
	logic [`PSC_IG_W-1:0]     igcfg_ff;
	logic                     oe_cmd_wr;
	logic                     restart;

	assign oe_cmd_wr = psc_wr_hit(wr_ff, addr_ff, `PSC_A_OECMD);
	assign restart   = psc_wr_hit(wr_ff, addr_ff, `PSC_A_CMD)
		&& hwdata[`PSC_CMD_BIT];

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ctl_ff   <= '0;
			dsel_ff  <= '0;
			route_ff <= '0;
		end else begin
			if (psc_wr_hit(wr_ff, addr_ff, `PSC_A_CTRL))
				ctl_ff <= hwdata[`PSC_NCH-1:0];
			if (psc_wr_hit(wr_ff, addr_ff, `PSC_A_DSEL))
				dsel_ff <= hwdata[`PSC_NCH-1:0];
			if (psc_wr_hit(wr_ff, addr_ff, `PSC_A_ROUTE))
				route_ff <= hwdata[`PSC_RTR_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			lscfg_ff  <= '0;
			lscfge_ff <= '0;
			brcfg_ff  <= '0;
			brcfgb_ff <= 1'b0;
			igcfg_ff  <= '0;
		end else begin
			if (psc_wr_hit(wr_ff, addr_ff, `PSC_A_LSCFG))
				lscfg_ff <= hwdata[`PSC_LS_W-1:0];
			if (psc_wr_hit(wr_ff, addr_ff, `PSC_A_LSCFGE))
				lscfge_ff <= hwdata[`PSC_LSE_W-1:0];
			if (psc_wr_hit(wr_ff, addr_ff, `PSC_A_BRCFG))
				brcfg_ff <= hwdata[`PSC_BR_W-1:0];
			if (psc_wr_hit(wr_ff, addr_ff, `PSC_A_BRCFGB))
				brcfgb_ff <= hwdata[`PSC_DLY_B_BIT];
			if (psc_wr_hit(wr_ff, addr_ff, `PSC_A_IGCFG))
				igcfg_ff <= hwdata[`PSC_IG_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn)
			oe_ff <= 1'b0;
		else if (oe_cmd_wr)
			oe_ff <= hwdata[`PSC_OE_BIT];
	end

	// Protection beats any software set in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (!resetn)
			per_en_ff <= '0;
		else if (oe_cmd_wr && hwdata[`PSC_OE_BIT])
			per_en_ff <= ~prot_s;
		else if (oe_cmd_wr)
			per_en_ff <= '0;
		else if (psc_wr_hit(wr_ff, addr_ff, `PSC_A_PEN))
			per_en_ff <= hwdata[`PSC_NCH-1:0] & ~prot_s;
		else
			per_en_ff <= per_en_ff & ~prot_s;
	end

	psc_chan_t dd;
	psc_chan_t conflict;
	psc_chan_t gate;
	psc_chan_t src;
	logic [2:0] hits;

	always_comb begin
		dd       = '0;
		conflict = '0;
		hits     = 3'h0;
		dd[`PSC_INJ_HI:`PSC_INJ_LO] = pin_s[`PSC_INJ_HI:`PSC_INJ_LO];
		dd[`PSC_IGN_HI:`PSC_IGN_LO] = pin_s[`PSC_IGNP_HI:`PSC_IGNP_LO];
		for (int i = 0; i < `PSC_NCH; i++) begin
			hits = 3'h0;
			for (int j = 0; j < `PSC_NRT; j++) begin
				if (psc_route_hit(route_ff[j*`PSC_RT_W +: `PSC_RT_W], i)) begin
					hits  = hits + 3'h1;
					dd[i] = dd[i] | pin_s[`PSC_RT_PIN0 + j];
				end
			end
			conflict[i] = hits > 3'h1;
		end
	end

	always_comb begin
		gate = '1;
		for (int i = 0; i < `PSC_NCH; i++) begin
			if (i <= `PSC_INJ_HI)
				gate[i] = inj_s;
			else if (i >= `PSC_IGN_LO)
				gate[i] = ign_s;
		end
	end

	assign src = (dsel_ff & dd) | (~dsel_ff & ctl_ff);

	logic trig;
	logic trig_ff;
	logic mode_a;
	logic mode_b;
	logic hold_a;
	logic hold_b;

	assign trig   = uv_s || ov_s || tout_s || !mon_s || !rstp_s;

	// Reset to active: synced low-active pins read asserted after reset.
	always_ff @(posedge ref_clk) begin
		if (!resetn)
			trig_ff <= 1'b1;
		else
			trig_ff <= trig;
	end
	assign mode_a = lscfge_ff[`PSC_DLY_A_BIT] && !dsel_ff[`PSC_CH_A];
	// Full-bridge use is not allowed with the hold, so it drops the mode.
	assign mode_b = brcfgb_ff && !dsel_ff[`PSC_CH_B]
		&& !brcfg_ff[`PSC_BR_FULL_A];

	psc_dly_if dly_a ();
	psc_dly_if dly_b ();

	assign dly_a.mode    = mode_a;
	assign dly_a.keep    = ctl_ff[`PSC_CH_A] && per_en_ff[`PSC_CH_A]
		&& oe_ff;
	assign dly_a.on_now  = power_out[`PSC_CH_A] && !trig_ff;
	assign dly_a.trigger = trig;
	assign dly_a.restart = restart;
	assign dly_a.ready   = rdy_s;
	assign hold_a        = dly_a.hold;

	assign dly_b.mode    = mode_b;
	assign dly_b.keep    = ctl_ff[`PSC_CH_B] && per_en_ff[`PSC_CH_B]
		&& oe_ff;
	assign dly_b.on_now  = power_out[`PSC_CH_B] && !trig_ff;
	assign dly_b.trigger = trig;
	assign dly_b.restart = restart;
	assign dly_b.ready   = rdy_s;
	assign hold_b        = dly_b.hold;

	psc_dly_off #(.DLY_CYCLES(DLY_CYCLES)) u_dly_a (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.dif     (dly_a)
	);

	psc_dly_off #(.DLY_CYCLES(DLY_CYCLES)) u_dly_b (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.dif     (dly_b)
	);

	psc_chan_t power_ff;
	psc_chan_t nxt_power;

	always_comb begin
		nxt_power = src & per_en_ff & gate & ~(conflict & dsel_ff)
			& {`PSC_NCH{oe_ff && !tout_s}};
		// An armed delayed channel rides through the trigger cycle.
		nxt_power[`PSC_CH_A] = (nxt_power[`PSC_CH_A] && !trig) || hold_a
			|| (mode_a && dly_a.on_now && trig);
		nxt_power[`PSC_CH_B] = (nxt_power[`PSC_CH_B] && !trig) || hold_b
			|| (mode_b && dly_b.on_now && trig);
		if (bat_s)
			nxt_power = '0;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn)
			power_ff <= '0;
		else
			power_ff <= nxt_power;
	end

	assign power_out             = power_ff;
	assign lowside_oc_limit      = lscfg_ff;
	assign lowside_diag_pull     = lscfge_ff[`PSC_LS_W-1:0];
	assign bridge_mode           = brcfg_ff;
	assign ignition_openload_cfg = igcfg_ff;
	assign relay_output_delayed  = hold_a;
	assign bridge_output_delayed = hold_b;

	always_comb begin
		rd_val = '0;
		case (addr_ff)
			`PSC_A_CTRL:   rd_val = 32'(ctl_ff);
			`PSC_A_DSEL:   rd_val = 32'(dsel_ff);
			`PSC_A_ROUTE:  rd_val = 32'(route_ff);
			`PSC_A_PEN:    rd_val = 32'(per_en_ff);
			`PSC_A_LSCFG:  rd_val = 32'(lscfg_ff);
			`PSC_A_LSCFGE: rd_val = 32'(lscfge_ff);
			`PSC_A_BRCFG:  rd_val = 32'(brcfg_ff);
			`PSC_A_BRCFGB: rd_val = 32'(brcfgb_ff);
			`PSC_A_IGCFG:  rd_val = 32'(igcfg_ff);
			`PSC_A_STAT: begin
				rd_val[`PSC_ST_OE]     = oe_ff;
				rd_val[`PSC_ST_TOUT]   = tout_s;
				rd_val[`PSC_ST_BATOV]  = bat_s;
				rd_val[`PSC_ST_HOLD_A] = hold_a;
				rd_val[`PSC_ST_HOLD_B] = hold_b;
				rd_val[`PSC_ST_CONF]   = |(conflict & dsel_ff);
			end
			default: rd_val = '0;
		endcase
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_oe_off;
		oe_cmd_wr && !hwdata[`PSC_OE_BIT];
	endsequence

	a_tout_off: assert property (tout_s |=> (power_ff & ~PAIR) == '0)
		else $error("output on during downlink time-out");
	a_batov_off: assert property (bat_s |=> power_ff == '0)
		else $error("output on during battery overvoltage");
	a_conflict_off: assert property ((conflict & dsel_ff) != '0
		|=> (power_ff & $past(conflict & dsel_ff)) == '0)
		else $error("output on with double assignment");
	a_oe_set_all: assert property (oe_cmd_wr && hwdata[`PSC_OE_BIT]
		|=> oe_ff && per_en_ff == ~$past(prot_s))
		else $error("central enable did not set enables");
	a_oe_clr_all: assert property (s_oe_off
		|=> (per_en_ff == '0 && !oe_ff) ##2 power_ff == '0)
		else $error("central disable left a channel on");
	a_prot_clear: assert property (prot_s != '0
		|=> (per_en_ff & $past(prot_s)) == '0)
		else $error("enable kept under protection");
	a_inj_gate: assert property (!inj_s
		|=> power_ff[`PSC_INJ_HI:`PSC_INJ_LO] == '0)
		else $error("injector on without enable pin");
	a_ign_gate: assert property (!ign_s
		|=> power_ff[`PSC_IGN_HI:`PSC_IGN_LO] == '0)
		else $error("ignition on without enable pin");
	a_ctrl_on: assert property (ctl_ff[0] && !dsel_ff[0] && per_en_ff[0]
		&& oe_ff && inj_s && !tout_s && !bat_s |=> power_ff[0])
		else $error("commanded output stayed off");
	a_out_needs_en: assert property (1'b1 |=>
		(power_ff & ~PAIR & ~$past(per_en_ff)) == '0)
		else $error("output on without its enable");
endmodule : psc_top

//--- test/psc_mcu_model.sv
`timescale 1ns/1ps
`include "psc_defs.svh"
module psc_mcu_model (
	input  wire logic                 ref_clk,
	input  wire logic [`PSC_NPIN-1:0] want_pins,
	input  wire logic                 want_inj,
	input  wire logic                 want_ign,
	output logic      [`PSC_NPIN-1:0] direct_drive_pin,
	output logic                      injector_enable_pin,
	output logic                      ignition_enable_pin
);
	// Port pins change only on the controller's clock edge.
	// This mimics a port register rather than a glitching line.
	initial begin
		direct_drive_pin    = 12'h000;
		injector_enable_pin = 1'b0;
		ignition_enable_pin = 1'b0;
	end
	always @(posedge ref_clk) begin
		direct_drive_pin    <= want_pins;
		injector_enable_pin <= want_inj;
		ignition_enable_pin <= want_ign;
	end
endmodule : psc_mcu_model

//--- test/tb_top.sv
`timescale 1ns/1ps
`include "psc_defs.svh"
module tb_top import psc_pkg::*; ;
	logic                 ref_clk;
	logic                 resetn;
	logic                 hsel;
	logic [31:0]          haddr;
	logic [1:0]           htrans;
	logic                 hwrite;
	logic [31:0]          hwdata;
	logic                 hreadyout;
	logic                 hresp;
	logic [31:0]          hrdata;
	logic [`PSC_NPIN-1:0] pins;
	logic [`PSC_NPIN-1:0] want_pins;
	logic                 inj_pin;
	logic                 ign_pin;
	logic                 want_inj;
	logic                 want_ign;
	logic                 tout;
	logic                 batov;
	logic                 uv;
	logic                 ov;
	logic                 mon_n;
	logic                 rst_pin_n;
	logic                 rdy;
	psc_chan_t            prot;
	psc_chan_t            pout;
	logic [23:0]          ls_oc;
	logic [23:0]          ls_pull;
	logic [11:0]          br_mode;
	logic [9:0]           ig_cfg;
	logic                 hold_a;
	logic                 hold_b;
	logic [31:0]          rd;
	int                   n_errors;
	int                   total_checks;
	int                   cyc;

	psc_mcu_model i_psc_mcu_model (.ref_clk(ref_clk), .want_pins(want_pins),
		.want_inj(want_inj), .want_ign(want_ign), .direct_drive_pin(pins),
		.injector_enable_pin(inj_pin), .ignition_enable_pin(ign_pin));

	psc_top #(.DLY_CYCLES(20)) i_psc_top (.ref_clk(ref_clk),
		.resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.direct_drive_pin(pins), .injector_enable_pin(inj_pin),
		.ignition_enable_pin(ign_pin), .downlink_timeout(tout),
		.bat_overvoltage(batov), .main_supply_uv(uv), .main_supply_ov(ov),
		.monitor_n(mon_n), .reset_pin_n(rst_pin_n), .ready_state(rdy),
		.protect_active(prot), .power_out(pout), .lowside_oc_limit(ls_oc),
		.lowside_diag_pull(ls_pull), .bridge_mode(br_mode),
		.ignition_openload_cfg(ig_cfg), .relay_output_delayed(hold_a),
		.bridge_output_delayed(hold_b));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task finish_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	task check(input string name, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask : check

	task wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_cyc

	// The address phase is held until hready is seen high, then the data
	// phase is held the same way; read data are taken at that last edge.
	task ahb_xfer(input logic wr, input logic [31:0] a, d);
		@(posedge ref_clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb_xfer

	task wr(input logic [31:0] a, d);
		ahb_xfer(1'b1, a, d);
		wait_cyc(2);
	endtask : wr

	task rd_chk(input string name, input logic [31:0] a, exp);
		ahb_xfer(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask : rd_chk

	task pout_chk(input string name, input int n, input psc_chan_t exp);
		wait_cyc(n);
		check(name, {4'h0, pout}, {4'h0, exp});
	endtask : pout_chk

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			finish_test();
		end
	end

	initial begin
		n_errors = 0;
		total_checks = 0;
		cyc = 0;
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		want_pins = 12'h000;
		want_inj = 1'b1;
		want_ign = 1'b1;
		{tout, batov, uv, ov, rdy} = 5'h00;
		{mon_n, rst_pin_n} = 2'h3;
		prot = 28'h0000004;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		wait_cyc(4);
		rd_chk("stat_rst", `PSC_A_STAT, 32'h0);
		check("hresp", {31'h0, hresp}, 32'h0);
		pout_chk("pout_rst", 0, 28'h0);
		wr(32'h3C, 32'hFFFFFFFF);
		rd_chk("unmapped", 32'h3C, 32'h0);
		rd_chk("stat_again", `PSC_A_STAT, 32'h0);
		wr(`PSC_A_OECMD, 32'h1);
		rd_chk("stat_oe", `PSC_A_STAT, 32'h1);
		rd_chk("pen_set", `PSC_A_PEN, 32'h0FFFFFFB);
		wr(`PSC_A_PEN, 32'h0FFFFFFF);
		rd_chk("pen_prot", `PSC_A_PEN, 32'h0FFFFFFB);
		wr(`PSC_A_CTRL, 32'h01000025);
		pout_chk("ctrl_on", 0, 28'h1000021);
		want_inj <= 1'b0;
		pout_chk("inj_gate", 5, 28'h1000020);
		want_ign <= 1'b0;
		pout_chk("ign_gate", 5, 28'h0000020);
		want_inj <= 1'b1;
		want_ign <= 1'b1;
		wr(`PSC_A_CTRL, 32'h0);
		wr(`PSC_A_DSEL, 32'h01000201);
		wr(`PSC_A_ROUTE, 32'h9);
		want_pins <= 12'h111;
		pout_chk("direct", 5, 28'h1000201);
		wr(`PSC_A_ROUTE, 32'h129);
		pout_chk("conflict", 0, 28'h1000001);
		rd_chk("stat_conf", `PSC_A_STAT, 32'h21);
		want_pins <= 12'h000;
		wr(`PSC_A_DSEL, 32'h0);
		wr(`PSC_A_CTRL, 32'h21);
		tout <= 1'b1;
		pout_chk("timeout", 5, 28'h0);
		rd_chk("stat_tout", `PSC_A_STAT, 32'h3);
		tout <= 1'b0;
		pout_chk("tout_gone", 5, 28'h21);
		batov <= 1'b1;
		pout_chk("batov", 5, 28'h0);
		batov <= 1'b0;
		wr(`PSC_A_LSCFG, 32'h00A5A5A5);
		check("oc_limit", {8'h0, ls_oc}, 32'h00A5A5A5);
		wr(`PSC_A_LSCFGE, 32'h005A5A5A);
		check("diag_pull", {8'h0, ls_pull}, 32'h005A5A5A);
		wr(`PSC_A_BRCFG, 32'h00000C3C);
		check("bridge", {20'h0, br_mode}, 32'h00000C3C);
		wr(`PSC_A_IGCFG, 32'h000002D5);
		check("ign_cfg", {22'h0, ig_cfg}, 32'h000002D5);
		// Both delayed channels stay register-controlled, and the bridge
		// channel is not in full-bridge use, so delayed mode is legal.
		wr(`PSC_A_LSCFGE, 32'h01000000);
		wr(`PSC_A_CTRL, 32'h00110000);
		uv <= 1'b1;
		pout_chk("dly_start", 5, 28'h0010000);
		check("hold_a", {31'h0, hold_a}, 32'h1);
		pout_chk("dly_min", 10, 28'h0010000);
		wr(`PSC_A_CMD, 32'h1);
		pout_chk("restart", 15, 28'h0010000);
		pout_chk("overflow", 12, 28'h0);
		check("hold_a_end", {31'h0, hold_a}, 32'h0);
		uv <= 1'b0;
		pout_chk("dly_again", 5, 28'h0110000);
		ov <= 1'b1;
		wait_cyc(5);
		check("hold_a2", {31'h0, hold_a}, 32'h1);
		ov <= 1'b0;
		rdy <= 1'b1;
		wait_cyc(5);
		check("ready_end", {31'h0, hold_a}, 32'h0);
		rdy <= 1'b0;
		wr(`PSC_A_BRCFGB, 32'h1);
		mon_n <= 1'b0;
		wait_cyc(5);
		check("hold_b", {31'h0, hold_b}, 32'h1);
		pout_chk("hold_both", 0, 28'h0110000);
		prot <= 28'h0010004;
		pout_chk("prot_off", 6, 28'h0100000);
		prot <= 28'h0000004;
		wr(`PSC_A_OECMD, 32'h0);
		check("oe_off_b", {31'h0, hold_b}, 32'h0);
		pout_chk("oe_off", 0, 28'h0);
		rd_chk("pen_clr", `PSC_A_PEN, 32'h0);
		mon_n <= 1'b1;
		finish_test();
	end
endmodule : tb_top
